// ==== core/sbd_dev_end.sv ====
// usb controller end: sideband pin logic with apb configuration and interrupt registers
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module sbd_dev_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        host_xfer_need,
  input  wire logic        periph_xfer_need,
  input  wire logic        host_irq_need,
  input  wire logic        periph_irq_need,
  input  wire logic [1:0]  sleep_enter,
  output logic      [1:0]  sleeping,
  output logic      [1:0]  wake_seen,
  output logic             host_grant,
  output logic             periph_grant,
  sbd_link_if.dev          link
);
  logic [15:0] host_cfg_r;
  logic [15:0] host_cfg_nxt;
  logic [15:0] periph_cfg_r;
  logic [15:0] periph_cfg_nxt;
  logic [3:0]  stat_r;
  logic [3:0]  stat_nxt;
  logic [3:0]  en_r;
  logic [3:0]  en_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic        wr_en;
  logic        mapped;
  logic [3:0]  ev;
  logic [3:0]  clr;
  logic        host_grant_r;
  logic        periph_grant_r;
  logic [1:0]  sleep_oe_n;
  logic [1:0]  wake_r;
  logic [1:0]  pin_oe_r;

  // bus slave: no wait state, answer at the first access cycle
  always_comb begin
    wr_en          = psel & penable & pready_r & pwrite;
    mapped         = (paddr == sbd_pkg::HOST_CFG_ADDR) || (paddr == sbd_pkg::PERIPH_CFG_ADDR) ||
                     (paddr == sbd_pkg::IRQ_STAT_ADDR) || (paddr == sbd_pkg::IRQ_CLR_ADDR) ||
                     (paddr == sbd_pkg::IRQ_EN_ADDR) || (paddr == sbd_pkg::STATE_ADDR);
    pready_nxt     = psel & ~penable;
    pslverr_nxt    = psel & ~penable & ~mapped;
    prdata_nxt     = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        sbd_pkg::HOST_CFG_ADDR:   prdata_nxt = {16'h0000, host_cfg_r};
        sbd_pkg::PERIPH_CFG_ADDR: prdata_nxt = {16'h0000, periph_cfg_r};
        sbd_pkg::IRQ_STAT_ADDR:   prdata_nxt = {28'h0000000, stat_r};
        sbd_pkg::IRQ_EN_ADDR:     prdata_nxt = {28'h0000000, en_r};
        sbd_pkg::STATE_ADDR:      prdata_nxt = {26'h0000000, periph_grant_r, host_grant_r, wake_r, sleep_oe_n};
        default:                  prdata_nxt = 32'h0000_0000;
      endcase
    end
    host_cfg_nxt   = host_cfg_r;
    periph_cfg_nxt = periph_cfg_r;
    en_nxt         = en_r;
    clr            = 4'h0;
    if (wr_en) begin
      unique case (paddr)
        sbd_pkg::HOST_CFG_ADDR:   host_cfg_nxt   = pwdata[15:0];
        sbd_pkg::PERIPH_CFG_ADDR: periph_cfg_nxt = pwdata[15:0];
        sbd_pkg::IRQ_CLR_ADDR:    clr            = pwdata[3:0];
        sbd_pkg::IRQ_EN_ADDR:     en_nxt         = pwdata[3:0];
        default:                  clr            = 4'h0;
      endcase
    end
    // sticky status, a new event wins over a clear in the same cycle
    stat_nxt       = (stat_r & ~clr) | ev;
    irq_nxt        = |(stat_nxt & en_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_cfg_r   <= sbd_pkg::HOST_CFG_RST;
      periph_cfg_r <= sbd_pkg::PERIPH_CFG_RST;
      stat_r       <= 4'h0;
      en_r         <= sbd_pkg::IRQ_EN_RST;
      irq_r        <= 1'b0;
      prdata_r     <= 32'h0000_0000;
      pready_r     <= 1'b0;
      pslverr_r    <= 1'b0;
    end else begin
      host_cfg_r   <= host_cfg_nxt;
      periph_cfg_r <= periph_cfg_nxt;
      stat_r       <= stat_nxt;
      en_r         <= en_nxt;
      irq_r        <= irq_nxt;
      prdata_r     <= prdata_nxt;
      pready_r     <= pready_nxt;
      pslverr_r    <= pslverr_nxt;
    end
  end

  // dma request, grant and interrupt pins
  logic merge_irq_lines;
  logic merge_dma_channels;
  logic host_grant_act;
  logic periph_grant_act;
  logic host_req_act;
  logic periph_req_act;
  logic host_irq_act;
  logic periph_irq_act;
  logic host_req_r;
  logic host_req_nxt;
  logic periph_req_r;
  logic periph_req_nxt;
  logic host_int_r;
  logic host_int_nxt;
  logic periph_int_r;
  logic periph_int_nxt;
  logic host_grant_nxt;
  logic periph_grant_nxt;

  always_comb begin
    merge_irq_lines    = host_cfg_r[sbd_pkg::MERGE_IRQ_BIT];
    merge_dma_channels = host_cfg_r[sbd_pkg::MERGE_DMA_BIT];
    host_grant_act     = link.host_dma_grant == host_cfg_r[sbd_pkg::GRANT_POL_BIT];
    periph_grant_act   = link.periph_dma_grant == periph_cfg_r[sbd_pkg::GRANT_POL_BIT];
    host_req_act       = host_xfer_need | (merge_dma_channels & periph_xfer_need);
    periph_req_act     = periph_xfer_need & ~merge_dma_channels;
    host_irq_act       = host_irq_need | (merge_irq_lines & periph_irq_need);
    periph_irq_act     = periph_irq_need & ~merge_irq_lines;
    host_req_nxt       = ~(host_req_act ^ host_cfg_r[sbd_pkg::REQ_POL_BIT]);
    periph_req_nxt     = ~(periph_req_act ^ periph_cfg_r[sbd_pkg::REQ_POL_BIT]);
    host_int_nxt       = ~(host_irq_act ^ host_cfg_r[sbd_pkg::IRQ_POL_BIT]);
    periph_int_nxt     = ~(periph_irq_act ^ periph_cfg_r[sbd_pkg::IRQ_POL_BIT]);
    if (merge_dma_channels) begin
      // shared grant goes to the host controller first, else to the peripheral controller
      host_grant_nxt   = host_grant_act & (host_xfer_need | ~periph_xfer_need);
      periph_grant_nxt = host_grant_act & periph_xfer_need & ~host_xfer_need;
    end else begin
      host_grant_nxt   = host_grant_act;
      periph_grant_nxt = periph_grant_act;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_req_r     <= 1'b1;
      periph_req_r   <= 1'b1;
      host_int_r     <= 1'b1;
      periph_int_r   <= 1'b1;
      host_grant_r   <= 1'b0;
      periph_grant_r <= 1'b0;
    end else begin
      host_req_r     <= host_req_nxt;
      periph_req_r   <= periph_req_nxt;
      host_int_r     <= host_int_nxt;
      periph_int_r   <= periph_int_nxt;
      host_grant_r   <= host_grant_nxt;
      periph_grant_r <= periph_grant_nxt;
    end
  end

  // suspend and wake per controller
  for (genvar g = 0; g < 2; g++) begin : g_sleep
    sbd_pkg::sbd_sleep_t st_r;
    sbd_pkg::sbd_sleep_t st_nxt;
    logic                wake_nxt;
    always_comb begin
      st_nxt   = st_r;
      wake_nxt = 1'b0;
      unique case (st_r)
        sbd_pkg::SBD_AWAKE: begin
          if (sleep_enter[g]) begin
            st_nxt = sbd_pkg::SBD_ASLEEP;
          end
        end
        sbd_pkg::SBD_ASLEEP: begin
          if (!link.pin_level[g]) begin
            st_nxt   = sbd_pkg::SBD_AWAKE;
            wake_nxt = 1'b1;
          end
        end
      endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_r          <= sbd_pkg::SBD_AWAKE;
        wake_r[g]     <= 1'b0;
        pin_oe_r[g]   <= 1'b0;
        sleep_oe_n[g] <= 1'b1;
      end else begin
        st_r          <= st_nxt;
        wake_r[g]     <= wake_nxt;
        pin_oe_r[g]   <= st_nxt == sbd_pkg::SBD_AWAKE;
        sleep_oe_n[g] <= st_nxt == sbd_pkg::SBD_ASLEEP;
      end
    end
  end

  always_comb begin
    ev                           = 4'h0;
    ev[sbd_pkg::EV_HOST_WAKE]    = wake_r[sbd_pkg::CH_HOST];
    ev[sbd_pkg::EV_PERIPH_WAKE]  = wake_r[sbd_pkg::CH_PERIPH];
    ev[sbd_pkg::EV_HOST_GRANT]   = host_grant_nxt & ~host_grant_r;
    ev[sbd_pkg::EV_PERIPH_GRANT] = periph_grant_nxt & ~periph_grant_r;
  end

  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign irq                     = irq_r;
  assign sleeping                = sleep_oe_n;
  assign wake_seen               = wake_r;
  assign host_grant              = host_grant_r;
  assign periph_grant            = periph_grant_r;
  assign link.host_dma_request   = host_req_r;
  assign link.periph_dma_request = periph_req_r;
  assign link.host_irq_out       = host_int_r;
  assign link.periph_irq_out     = periph_int_r;
  assign link.dev_pin_o          = 2'b00;
  assign link.dev_pin_oe         = pin_oe_r;
endmodule // sbd_dev_end

// ==== core/sbd_far_end.sv ====
// system end: dma controller grants, interrupt sampling and wake pulses
`timescale 1ns/1ps
module sbd_far_end (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] req_pol,
  input  wire logic [1:0] grant_pol,
  input  wire logic [1:0] irq_pol,
  input  wire logic [1:0] grant_give,
  input  wire logic [1:0] wake_req,
  output logic      [1:0] req_seen,
  output logic      [1:0] irq_seen,
  output logic      [1:0] sleep_seen,
  output logic      [1:0] wake_busy,
  sbd_link_if.far         link
);
  logic [1:0] grant_r;
  logic [1:0] grant_nxt;
  logic [1:0] req_r;
  logic [1:0] req_nxt;
  logic [1:0] irq_r;
  logic [1:0] irq_nxt;
  logic [1:0] sleep_r;
  logic [1:0] sleep_nxt;
  logic [1:0] pin_oe_r;

  always_comb begin
    grant_nxt = ~(grant_give ^ grant_pol);
    req_nxt   = ~({link.periph_dma_request, link.host_dma_request} ^ req_pol);
    irq_nxt   = ~({link.periph_irq_out, link.host_irq_out} ^ irq_pol);
    sleep_nxt = link.pin_level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_r <= 2'b11;
      req_r   <= 2'b00;
      irq_r   <= 2'b00;
      sleep_r <= 2'b00;
    end else begin
      grant_r <= grant_nxt;
      req_r   <= req_nxt;
      irq_r   <= irq_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // low wake pulse of fixed length on each sleep and wake pin
  for (genvar g = 0; g < 2; g++) begin : g_wake
    sbd_pkg::sbd_wake_t                st_r;
    sbd_pkg::sbd_wake_t                st_nxt;
    logic [sbd_pkg::CNT_W-1:0]         cnt_r;
    logic [sbd_pkg::CNT_W-1:0]         cnt_nxt;
    always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      unique case (st_r)
        sbd_pkg::SBD_IDLE: begin
          if (wake_req[g]) begin
            st_nxt  = sbd_pkg::SBD_PULSE;
            cnt_nxt = sbd_pkg::CNT_W'(sbd_pkg::WAKE_PULSE_CYC - 1);
          end
        end
        sbd_pkg::SBD_PULSE: begin
          if (cnt_r == '0) begin
            st_nxt = sbd_pkg::SBD_IDLE;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
      endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_r        <= sbd_pkg::SBD_IDLE;
        cnt_r       <= '0;
        pin_oe_r[g] <= 1'b0;
      end else begin
        st_r        <= st_nxt;
        cnt_r       <= cnt_nxt;
        pin_oe_r[g] <= st_nxt == sbd_pkg::SBD_PULSE;
      end
    end
  end

  assign link.host_dma_grant   = grant_r[sbd_pkg::CH_HOST];
  assign link.periph_dma_grant = grant_r[sbd_pkg::CH_PERIPH];
  assign link.far_pin_o        = 2'b00;
  assign link.far_pin_oe       = pin_oe_r;
  assign req_seen              = req_r;
  assign irq_seen              = irq_r;
  assign sleep_seen            = sleep_r;
  assign wake_busy             = pin_oe_r;
endmodule // sbd_far_end

// ==== core/sbd_link_if.sv ====
// sideband wires between the usb controller end and the system end
`timescale 1ns/1ps
interface sbd_link_if;
  logic       host_dma_request;
  logic       periph_dma_request;
  logic       host_dma_grant;
  logic       periph_dma_grant;
  logic       host_irq_out;
  logic       periph_irq_out;
  logic [1:0] dev_pin_o;
  logic [1:0] dev_pin_oe;
  logic [1:0] far_pin_o;
  logic [1:0] far_pin_oe;
  logic [1:0] pin_level;
  // open-drain wires with pull-up: bit 0 host_sleep_wake_pin, bit 1 periph_sleep_wake_pin
  assign pin_level = ~((dev_pin_oe & ~dev_pin_o) | (far_pin_oe & ~far_pin_o));
  modport dev (
    output host_dma_request, periph_dma_request, host_irq_out, periph_irq_out, dev_pin_o, dev_pin_oe,
    input  host_dma_grant, periph_dma_grant, pin_level
  );
  modport far (
    input  host_dma_request, periph_dma_request, host_irq_out, periph_irq_out, pin_level,
    output host_dma_grant, periph_dma_grant, far_pin_o, far_pin_oe
  );
endinterface

// ==== core/sbd_pkg.sv ====
// constants and types shared by both ends of the dma, interrupt and suspend sideband
// Function
// - periph dma request, polarity from periph config
// - far end drives host dma grant
// - host grant polarity from host config
// - far end drives periph dma grant
// - periph grant polarity from periph config
// - host interrupts on first irq line
// - merge bit routes both interrupts to first
// - periph interrupts on second irq line
// - host sleep pin released while host suspended
// - low pulse on host pin wakes host
// - periph sleep pin released while periph suspended
// - low pulse on periph pin wakes periph
// - host dma request, polarity from host config
// - dma merge routes both channels to host pins
package sbd_pkg;
  localparam int          CLK_MHZ         = 40;
  localparam int          WAKE_PULSE_NS   = 100;
  localparam int          WAKE_PULSE_CYC  = (WAKE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W           = 4;
  localparam int          CFG_W           = 16;
  localparam int          EV_W            = 4;
  localparam logic [11:0] HOST_CFG_IDX    = 12'h020;
  localparam logic [11:0] PERIPH_CFG_IDX  = 12'h0ba;
  localparam logic [11:0] HOST_CFG_ADDR   = 12'h080;
  localparam logic [11:0] PERIPH_CFG_ADDR = 12'h2e8;
  localparam logic [11:0] IRQ_STAT_ADDR   = 12'h300;
  localparam logic [11:0] IRQ_CLR_ADDR    = 12'h304;
  localparam logic [11:0] IRQ_EN_ADDR     = 12'h308;
  localparam logic [11:0] STATE_ADDR      = 12'h30c;
  localparam int          IRQ_POL_BIT     = 0;
  localparam int          REQ_POL_BIT     = 1;
  localparam int          GRANT_POL_BIT   = 2;
  localparam int          MERGE_IRQ_BIT   = 3;
  localparam int          MERGE_DMA_BIT   = 4;
  localparam logic [15:0] HOST_CFG_RST    = 16'h0000;
  localparam logic [15:0] PERIPH_CFG_RST  = 16'h0000;
  localparam logic [3:0]  IRQ_EN_RST      = 4'h0;
  localparam int          EV_HOST_WAKE    = 0;
  localparam int          EV_PERIPH_WAKE  = 1;
  localparam int          EV_HOST_GRANT   = 2;
  localparam int          EV_PERIPH_GRANT = 3;
  localparam int          CH_HOST         = 0;
  localparam int          CH_PERIPH       = 1;
  typedef enum logic {
    SBD_AWAKE  = 1'b0,
    SBD_ASLEEP = 1'b1
  } sbd_sleep_t;
  typedef enum logic {
    SBD_IDLE  = 1'b0,
    SBD_PULSE = 1'b1
  } sbd_wake_t;
endpackage

// ==== tb/sbd_bench.sv ====
// self-checking bench joining both sideband ends
`timescale 1ns/1ps
module sbd_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, b, host_grant, periph_grant;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  xn, inq, se, slp, ws, rp, gp, ip, gg, wk, rs, irs, ss, wb;
  int          n_fail, compares;
  sbd_link_if  link ();
  sbd_dev_end u_sbd_dev_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .host_xfer_need(xn[0]), .periph_xfer_need(xn[1]), .host_irq_need(inq[0]), .periph_irq_need(inq[1]),
    .sleep_enter(se), .sleeping(slp), .wake_seen(ws), .host_grant(host_grant), .periph_grant(periph_grant),
    .link(link));
  sbd_far_end u_sbd_far_end (.pclk(pclk), .presetn(presetn), .req_pol(rp), .grant_pol(gp), .irq_pol(ip),
    .grant_give(gg), .wake_req(wk), .req_seen(rs), .irq_seen(irs), .sleep_seen(ss), .wake_busy(wb), .link(link));
  sbd_props u_sbd_props (.pclk(pclk), .presetn(presetn), .host_dma_request(link.host_dma_request),
    .periph_dma_request(link.periph_dma_request), .host_dma_grant(link.host_dma_grant),
    .periph_dma_grant(link.periph_dma_grant), .host_irq_out(link.host_irq_out),
    .periph_irq_out(link.periph_irq_out), .dev_pin_o(link.dev_pin_o), .dev_pin_oe(link.dev_pin_oe),
    .far_pin_o(link.far_pin_o), .far_pin_oe(link.far_pin_oe), .pin_level(link.pin_level));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function logic [3:0] pins();
    return {link.host_dma_request, link.periph_dma_request, link.host_irq_out, link.periph_irq_out};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, waits for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk({31'h0, e}, 32'h0);
  endtask
  task cfg(input logic [15:0] h, input logic [15:0] p);
    wr(sbd_pkg::HOST_CFG_ADDR, {16'h0, h});
    wr(sbd_pkg::PERIPH_CFG_ADDR, {16'h0, p});
    rp <= {p[1], h[1]};
    gp <= {p[2], h[2]};
    ip <= {p[0], h[0]};
  endtask
  task t_reset();
    presetn <= 1'b0;
    cyc(4);
    chk(pins(), 4'hf);
    chk({link.pin_level, slp, ws, irq}, 7'h78);
    cyc(12);
    presetn <= 1'b1;
    cyc(2);
    rd(sbd_pkg::HOST_CFG_ADDR, 32'h0);
    rd(sbd_pkg::PERIPH_CFG_ADDR, 32'h0);
    rd(sbd_pkg::IRQ_EN_ADDR, 32'h0);
    rd(sbd_pkg::IRQ_CLR_ADDR, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({q[30:0], e}, 32'h1);
  endtask
  // both polarities of request, interrupt and grant
  task t_pol();
    for (int v = 0; v < 2; v++) begin
      b = v[0];
      cfg({13'h0, {3{b}}}, {13'h0, {3{b}}});
      xn <= 2'b11;
      inq <= 2'b11;
      cyc(3);
      chk(pins(), {4{b}});
      chk({rs, irs}, 4'hf);
      xn <= 2'b00;
      inq <= 2'b00;
      cyc(3);
      chk(pins(), {4{~b}});
      wr(sbd_pkg::IRQ_CLR_ADDR, 32'hf);
      wr(sbd_pkg::IRQ_EN_ADDR, 32'hc);
      gg <= 2'b11;
      cyc(3);
      chk({periph_grant, host_grant, irq}, 3'h7);
      rd(sbd_pkg::IRQ_STAT_ADDR, 32'hc);
      gg <= 2'b00;
      cyc(3);
      chk({periph_grant, host_grant}, 2'b00);
      wr(sbd_pkg::IRQ_CLR_ADDR, 32'hc);
      cyc(1);
      chk(irq, 1'b0);
    end
  endtask
  task t_merge();
    cfg(16'h001f, 16'h0007);
    xn <= 2'b10;
    inq <= 2'b10;
    cyc(3);
    chk(pins(), 4'ha);
    gg <= 2'b01;
    cyc(3);
    chk({periph_grant, host_grant}, 2'b10);
    gg <= 2'b00;
    xn <= 2'b00;
    inq <= 2'b00;
  endtask
  // suspend, stay suspended, wake by far pulse, interrupt raise, mask, clear
  task t_sleep(input int ch);
    wr(sbd_pkg::IRQ_CLR_ADDR, 32'hf);
    wr(sbd_pkg::IRQ_EN_ADDR, 32'h1 << ch);
    se[ch] <= 1'b1;
    cyc(1);
    se[ch] <= 1'b0;
    cyc(3);
    chk({slp[ch], link.pin_level[ch], ss[ch]}, 3'h7);
    cyc(8);
    chk({slp[ch], link.pin_level[ch]}, 2'b11);
    rd(sbd_pkg::STATE_ADDR, 32'h1 << ch);
    wk[ch] <= 1'b1;
    cyc(1);
    wk[ch] <= 1'b0;
    do @(posedge pclk); while (ws[ch] !== 1'b1);
    cyc(1);
    chk({slp[ch], link.pin_level[ch], irq, wb[ch]}, 4'h3);
    rd(sbd_pkg::IRQ_STAT_ADDR, 32'h1 << ch);
    wr(sbd_pkg::IRQ_EN_ADDR, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    chk(wb[ch], 1'b0);
    wr(sbd_pkg::IRQ_CLR_ADDR, 32'hf);
    wr(sbd_pkg::IRQ_EN_ADDR, 32'hf);
    cyc(1);
    chk(irq, 1'b0);
  endtask
  task stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, xn, inq, se, rp, gp, ip, gg, wk} = '0;
    presetn = 1'b0;
    n_fail = 0;
    compares = 0;
    t_reset();
    t_pol();
    t_merge();
    t_sleep(0);
    t_sleep(1);
    t_reset();
    stop_test();
  end
  // watchdog: wide margin over the roughly 220 cycles of the run
  initial begin
    #500000;
    n_fail++;
    stop_test();
  end
endmodule // sbd_bench

// ==== tb/sbd_props.sv ====
// assertions on the sideband wires between the two ends
`timescale 1ns/1ps
module sbd_props (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       host_dma_request,
  input wire logic       periph_dma_request,
  input wire logic       host_dma_grant,
  input wire logic       periph_dma_grant,
  input wire logic       host_irq_out,
  input wire logic       periph_irq_out,
  input wire logic [1:0] dev_pin_o,
  input wire logic [1:0] dev_pin_oe,
  input wire logic [1:0] far_pin_o,
  input wire logic [1:0] far_pin_oe,
  input wire logic [1:0] pin_level
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // open-drain: a driver only ever pulls low
  property p_dev_od;
    dev_pin_o == 2'b00;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("device pin driven high");
  property p_far_od;
    far_pin_o == 2'b00;
  endproperty
  a_far_od: assert property (p_far_od) else $error("far pin driven high");
  // far end wake pulse is four cycles low
  property p_pulse0;
    $rose(far_pin_oe[0]) |-> far_pin_oe[0] [*4] ##1 !far_pin_oe[0];
  endproperty
  a_pulse0: assert property (p_pulse0) else $error("host wake pulse length");
  property p_pulse1;
    $rose(far_pin_oe[1]) |-> far_pin_oe[1] [*4] ##1 !far_pin_oe[1];
  endproperty
  a_pulse1: assert property (p_pulse1) else $error("periph wake pulse length");
  // a low pulse seen while suspended wakes the controller next cycle
  property p_wake0;
    !dev_pin_oe[0] && far_pin_oe[0] |=> dev_pin_oe[0];
  endproperty
  a_wake0: assert property (p_wake0) else $error("host missed wake pulse");
  property p_wake1;
    !dev_pin_oe[1] && far_pin_oe[1] |=> dev_pin_oe[1];
  endproperty
  a_wake1: assert property (p_wake1) else $error("periph missed wake pulse");
  // suspended pin stays released while nobody pulls it low
  property p_stay0;
    !dev_pin_oe[0] && pin_level[0] && $past(presetn) |=> !dev_pin_oe[0];
  endproperty
  a_stay0: assert property (p_stay0) else $error("host left suspend unasked");
  property p_stay1;
    $rose(dev_pin_oe[1]) && $past(presetn, 2) |-> !$past(pin_level[1]);
  endproperty
  a_stay1: assert property (p_stay1) else $error("periph left suspend unasked");
  c_wake0: cover property ($rose(dev_pin_oe[0]) && $past(presetn, 2));
  c_wake1: cover property ($rose(dev_pin_oe[1]) && $past(presetn, 2));
  c_sleep: cover property ($fell(dev_pin_oe[0]));
  c_grant: cover property ($changed(host_dma_grant));
endmodule // sbd_props
